/* logic/abx_map.svh */
`ifndef ABX_MAP_SVH
`define ABX_MAP_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define ABX_DW 8
`define ABX_FW 7
`define ABX_BIW 3
`define ABX_AXI_AW 8

// ------------------------------------------------------------
// timing: oscillator periods (aclk cycles) per instruction cycle
// ------------------------------------------------------------
`define ABX_OSC_PER_CYC 4

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ABX_OFF_CTRL 8'h00
`define ABX_OFF_ACC 8'h04
`define ABX_OFF_STAT 8'h08

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ABX_CTRL_RUN 0
`define ABX_CTRL_IOA_LSB 8
`define ABX_CTRL_IOEN 15
`define ABX_STAT_C 0
`define ABX_STAT_DC 1
`define ABX_STAT_Z 2
`define ABX_STAT_SKIP 8

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define ABX_RUN_RST 1'b1
`define ABX_IOEN_RST 1'b0
`define ABX_IOA_RST 7'h06
`define ABX_ACC_RST 8'h00
`define ABX_RESP_OKAY 2'b00
`define ABX_RESP_SLVERR 2'b10

`endif

/* logic/abx_pkg.sv */
`include "abx_map.svh"
`default_nettype none

package abx_pkg;

  // ----------------------------------------------------------
  // operations handed over by the decoder
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    add_literal_op = 4'h0,
    add_register_op = 4'h1,
    and_register_op = 4'h2,
    and_literal_op = 4'h3,
    clear_bit_op = 4'h4,
    set_bit_op = 4'h5,
    skip_if_set_op = 4'h6,
    skip_if_clear_op = 4'h7,
    clear_register_op = 4'h8
  } abx_op_t;

  // ----------------------------------------------------------
  // instruction cycle phases, one-hot
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    ph_q1 = 4'b0001,
    ph_q2 = 4'b0010,
    ph_q3 = 4'b0100,
    ph_q4 = 4'b1000
  } abx_phase_t;

  typedef struct packed {
    abx_op_t op;
    logic [`ABX_DW-1:0] lit;
    logic [`ABX_FW-1:0] faddr;
    logic [`ABX_BIW-1:0] bit_idx;
    logic dest; // 0: accumulator, 1: file register
  } abx_instr_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } abx_flags_t;

  // ----------------------------------------------------------
  // complete state of the execution block
  // ----------------------------------------------------------
  typedef struct packed {
    abx_phase_t ph;
    abx_instr_t ins;
    logic live;
    logic skip_pend;
    logic op_ready;
    logic [`ABX_DW-1:0] acc;
    abx_flags_t fl;
    logic [`ABX_FW-1:0] rf_raddr;
    logic rf_we;
    logic [`ABX_FW-1:0] rf_waddr;
    logic [`ABX_DW-1:0] rf_wdata;
    logic skip_req;
    logic [`ABX_DW-1:0] pin_s1;
    logic [`ABX_DW-1:0] pin_s2;
    logic run;
    logic io_en;
    logic [`ABX_FW-1:0] io_addr;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [`ABX_AXI_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } abx_state_t;

endpackage

`default_nettype wire

/* logic/abx_alu.sv */
`default_nettype none

// ------------------------------------------------------------
// adder / and unit with carry, nibble carry and zero
// ------------------------------------------------------------
module abx_alu #(
  parameter int W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic use_and,
  output logic [W-1:0] y,
  output logic carry,
  output logic nib_carry,
  output logic zero
);

  logic [W:0] sum;
  logic [4:0] low_sum;

  if (W < 5) begin : g_chk
    $error("abx_alu needs at least 5 bits");
  end

  // full sum and low nibble sum
  assign sum = {1'b0, a} + {1'b0, b};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};

  // result and flags
  assign y = use_and ? (a & b) : sum[W-1:0];
  assign carry = sum[W];
  assign nib_carry = low_sum[4];
  assign zero = (y == '0);

endmodule

`default_nettype wire

/* logic/abx_exec.sv */
// Overview of operation
// - literal add puts accumulator plus 8-bit literal in accumulator; updates C, DC, Z.
// - register add sums accumulator with addressed file register; updates C, DC, Z.
// - destination bit 0 writes accumulator, 1 writes the file register back.
// - register AND goes to selected destination and changes only the zero flag.
// - literal AND puts result in accumulator and changes only the zero flag.
// - bit clear zeroes the indexed bit of the file register; flags untouched.
// - bit set forces the indexed bit to one; flags untouched, other bits kept except at the watched port, which takes the pin levels.
// - skip-if-set skips next instruction with an idle slot when bit is one.
// - skip-if-clear skips when bit is zero; neither skip test touches flags.
// - register clear writes zero to the file register and sets zero flag.
// - one instruction cycle is four clocks; non-skipping operations take one.
// - an I/O port register read as operand uses the synchronised pin levels.
`include "abx_map.svh"
`default_nettype none

module abx_exec
  import abx_pkg::*;
#(
  parameter int DATA_W = `ABX_DW,
  parameter int FADDR_W = `ABX_FW,
  parameter int ADDR_W = `ABX_AXI_AW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic op_valid,
  input wire abx_instr_t op_in,
  output logic op_ready,
  output logic [FADDR_W-1:0] rf_raddr,
  input wire logic [DATA_W-1:0] rf_rdata,
  output logic rf_we,
  output logic [FADDR_W-1:0] rf_waddr,
  output logic [DATA_W-1:0] rf_wdata,
  input wire logic [DATA_W-1:0] pin_level,
  output logic skip_req,
  output logic [DATA_W-1:0] acc_out,
  output logic [2:0] flags_out
);

  // ----------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------
  if (DATA_W != `ABX_DW || FADDR_W != `ABX_FW || ADDR_W != `ABX_AXI_AW) begin : g_chk_w
    $error("abx_exec widths must match the map header");
  end
  if (`ABX_OSC_PER_CYC != 4) begin : g_chk_ph
    $error("abx_exec phase ring serves four clocks per cycle only");
  end

  // ----------------------------------------------------------
  // state and datapath wires
  // ----------------------------------------------------------
  abx_state_t st_r;
  abx_state_t st_nxt;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_y;
  logic alu_and;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic bit_hit;
  logic [ADDR_W-1:0] rd_off;
  logic [ADDR_W-1:0] wr_off;

  // operand: pin levels for the watched port, file data otherwise
  assign opnd = (st_r.io_en && st_r.ins.faddr == st_r.io_addr) ?
                st_r.pin_s2 : rf_rdata;
  assign mask = DATA_W'(1) << st_r.ins.bit_idx;
  assign bit_hit = opnd[st_r.ins.bit_idx];

  // alu operand selection
  assign alu_b = (st_r.ins.op == add_literal_op || st_r.ins.op == and_literal_op) ?
                 st_r.ins.lit : opnd;
  assign alu_and = (st_r.ins.op == and_register_op || st_r.ins.op == and_literal_op);

  abx_alu #(
    .W(DATA_W)
  ) u_alu (
    .a(st_r.acc),
    .b(alu_b),
    .use_and(alu_and),
    .y(alu_y),
    .carry(alu_c),
    .nib_carry(alu_dc),
    .zero(alu_z)
  );

  // word-aligned offsets
  assign rd_off = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign wr_off = {st_r.waddr[ADDR_W-1:2], 2'b00};

  // ----------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rf_we = 1'b0;
    st_nxt.skip_req = 1'b0;

    // pin synchroniser
    st_nxt.pin_s1 = pin_level;
    st_nxt.pin_s2 = st_r.pin_s1;

    // axi write: address and data taken in either order
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_nxt.aw_have && st_nxt.w_have && !st_nxt.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `ABX_RESP_OKAY;
      unique case ({st_nxt.waddr[ADDR_W-1:2], 2'b00})
        `ABX_OFF_CTRL: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.run = st_nxt.wdata[`ABX_CTRL_RUN];
          end
          if (st_nxt.wstrb[1]) begin
            st_nxt.io_addr = st_nxt.wdata[`ABX_CTRL_IOA_LSB +: FADDR_W];
            st_nxt.io_en = st_nxt.wdata[`ABX_CTRL_IOEN];
          end
        end
        `ABX_OFF_ACC: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.acc = st_nxt.wdata[DATA_W-1:0];
          end
        end
        `ABX_OFF_STAT: begin
          if (st_nxt.wstrb[0]) begin
            st_nxt.fl.c = st_nxt.wdata[`ABX_STAT_C];
            st_nxt.fl.dc = st_nxt.wdata[`ABX_STAT_DC];
            st_nxt.fl.z = st_nxt.wdata[`ABX_STAT_Z];
          end
        end
        default: begin
          st_nxt.bresp = `ABX_RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

    // axi read: one-cycle answer
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `ABX_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      unique case (rd_off)
        `ABX_OFF_CTRL: begin
          st_nxt.rdata[`ABX_CTRL_RUN] = st_r.run;
          st_nxt.rdata[`ABX_CTRL_IOA_LSB +: FADDR_W] = st_r.io_addr;
          st_nxt.rdata[`ABX_CTRL_IOEN] = st_r.io_en;
        end
        `ABX_OFF_ACC: begin
          st_nxt.rdata[DATA_W-1:0] = st_r.acc;
        end
        `ABX_OFF_STAT: begin
          st_nxt.rdata[`ABX_STAT_C] = st_r.fl.c;
          st_nxt.rdata[`ABX_STAT_DC] = st_r.fl.dc;
          st_nxt.rdata[`ABX_STAT_Z] = st_r.fl.z;
          st_nxt.rdata[`ABX_STAT_SKIP] = st_r.skip_pend;
        end
        default: begin
          st_nxt.rresp = `ABX_RESP_SLVERR;
        end
      endcase
    end
    st_nxt.arready = !st_nxt.rvalid;

    // four-phase instruction cycle; execution wins over software writes
    unique case (st_r.ph)
      ph_q1: begin
        st_nxt.ph = ph_q2;
        st_nxt.op_ready = 1'b0;
        st_nxt.live = 1'b0;
        if (st_r.op_ready && op_valid) begin
          st_nxt.ins = op_in;
          st_nxt.rf_raddr = op_in.faddr;
          st_nxt.live = !st_r.skip_pend;
        end
        st_nxt.skip_pend = 1'b0;
      end
      ph_q2: begin
        st_nxt.ph = ph_q3;
      end
      ph_q3: begin
        st_nxt.ph = ph_q4;
        st_nxt.rf_waddr = st_r.ins.faddr;
        if (st_r.live) begin
          unique case (st_r.ins.op)
            add_literal_op: begin
              st_nxt.acc = alu_y;
              st_nxt.fl = '{z: alu_z, dc: alu_dc, c: alu_c};
            end
            add_register_op, and_register_op: begin
              if (st_r.ins.dest) begin
                st_nxt.rf_we = 1'b1;
                st_nxt.rf_wdata = alu_y;
              end else begin
                st_nxt.acc = alu_y;
              end
              st_nxt.fl.z = alu_z;
              if (st_r.ins.op == add_register_op) begin
                st_nxt.fl.c = alu_c;
                st_nxt.fl.dc = alu_dc;
              end
            end
            and_literal_op: begin
              st_nxt.acc = alu_y;
              st_nxt.fl.z = alu_z;
            end
            clear_bit_op: begin
              st_nxt.rf_we = 1'b1;
              st_nxt.rf_wdata = opnd & ~mask;
            end
            set_bit_op: begin
              st_nxt.rf_we = 1'b1;
              st_nxt.rf_wdata = opnd | mask;
            end
            skip_if_set_op: begin
              st_nxt.skip_req = bit_hit;
              st_nxt.skip_pend = bit_hit;
            end
            skip_if_clear_op: begin
              st_nxt.skip_req = !bit_hit;
              st_nxt.skip_pend = !bit_hit;
            end
            clear_register_op: begin
              st_nxt.rf_we = 1'b1;
              st_nxt.rf_wdata = '0;
              st_nxt.fl.z = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      ph_q4: begin
        st_nxt.ph = ph_q1;
        st_nxt.op_ready = st_r.run;
      end
      default: begin
        st_nxt.ph = ph_q1;
        st_nxt.op_ready = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ph <= ph_q1;
      st_r.ins.op <= add_literal_op;
      st_r.run <= `ABX_RUN_RST;
      st_r.io_en <= `ABX_IOEN_RST;
      st_r.io_addr <= `ABX_IOA_RST;
      st_r.acc <= `ABX_ACC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign op_ready = st_r.op_ready;
  assign rf_raddr = st_r.rf_raddr;
  assign rf_we = st_r.rf_we;
  assign rf_waddr = st_r.rf_waddr;
  assign rf_wdata = st_r.rf_wdata;
  assign skip_req = st_r.skip_req;
  assign acc_out = st_r.acc;
  assign flags_out = st_r.fl;

endmodule

`default_nettype wire

/* logic/abx_exec_end.sv */
`default_nettype none
`default_nettype wire

/* test/abx_exec_asserts.sv */
`include "abx_map.svh"
`default_nettype none

module abx_exec_asserts
  import abx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  input wire abx_instr_t op_in,
  input wire logic op_ready,
  input wire logic [`ABX_FW-1:0] rf_raddr,
  input wire logic rf_we,
  input wire logic [`ABX_FW-1:0] rf_waddr,
  input wire logic [`ABX_DW-1:0] rf_wdata,
  input wire logic skip_req,
  input wire logic [`ABX_DW-1:0] acc_out,
  input wire logic [2:0] flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // instruction slot checks
  // ----------------------------------------------------------
  logic tk;

  // an instruction is taken when offered in the open slot
  assign tk = op_ready && op_valid;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ready_spacing_a: assert property (op_ready |=> !op_ready [*3] ##1 op_ready)
    else $error("slot spacing broken");
  write_slot_a: assert property (rf_we |-> $past(op_ready, 3))
    else $error("file write outside its slot");
  skip_slot_a: assert property (skip_req |-> $past(op_ready, 3) && !rf_we)
    else $error("skip request outside its slot");
  read_addr_a: assert property (tk && !$past(skip_req) &&
    !(op_in.op inside {add_literal_op, and_literal_op}) |=> rf_raddr == $past(op_in.faddr))
    else $error("file read address wrong");
  lit_add_a: assert property (tk && !$past(skip_req) && op_in.op == add_literal_op |->
    ##3 ({flags_out[0], acc_out} == {1'b0, $past(acc_out, 3)} + {1'b0, $past(op_in.lit, 3)}))
    else $error("literal add result wrong");
  lit_and_a: assert property (tk && !$past(skip_req) && op_in.op == and_literal_op |->
    ##3 acc_out == ($past(acc_out, 3) & $past(op_in.lit, 3)) && flags_out[2] == (acc_out == 8'h00)
    && (flags_out & 3'h3) == ($past(flags_out, 3) & 3'h3))
    else $error("literal and result wrong");
  bit_flags_a: assert property (tk && op_in.op inside {clear_bit_op, set_bit_op,
    skip_if_set_op, skip_if_clear_op} |-> ##3 $stable(flags_out))
    else $error("bit operation touched flags");
  clr_reg_a: assert property (tk && !$past(skip_req) && op_in.op == clear_register_op |->
    ##3 rf_we && rf_wdata == 8'h00 && flags_out[2] && rf_waddr == $past(op_in.faddr, 3))
    else $error("register clear wrong");
  dest_sel_a: assert property (tk && !$past(skip_req) &&
    op_in.op inside {add_register_op, and_register_op} |-> ##3 rf_we == $past(op_in.dest, 3))
    else $error("destination select wrong");
  and_reg_a: assert property (tk && !$past(skip_req) && op_in.op == and_register_op |->
    ##3 (flags_out & 3'h3) == ($past(flags_out, 3) & 3'h3))
    else $error("register and changed carries");
endmodule

bind abx_exec abx_exec_asserts u_chk (.aclk, .aresetn, .op_valid, .op_in, .op_ready, .rf_raddr,
  .rf_we, .rf_waddr, .rf_wdata, .skip_req, .acc_out, .flags_out);

`default_nettype wire

/* test/abx_rf_model.sv */
`default_nettype none

module abx_rf_model (
  input wire logic aclk,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // file register array
  // ----------------------------------------------------------
  logic [7:0] mem [0:127];

  // read follows the address at once
  assign rdata = mem[raddr];

  // write lands at the edge that sees the strobe
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule

`default_nettype wire

/* test/tb.sv */
`include "abx_map.svh"
`default_nettype none

module tb
  import abx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // bench signals and expected state
  // ----------------------------------------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rf_rdata, rf_wdata, pin_level, acc_out, e_acc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic op_valid, op_ready, rf_we, skip_req, e_skip, e_ioen;
  logic [6:0] rf_raddr, rf_waddr, e_ioa, last_f;
  logic [2:0] flags_out, e_fl, bi;
  logic [7:0] e_mem [0:127];
  abx_instr_t op_in;
  int fails, checks_done;
  int skips = 0;

  abx_exec DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_valid, .op_in,
    .op_ready, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .pin_level, .skip_req,
    .acc_out, .flags_out);
  abx_rf_model rf (.aclk, .raddr(rf_raddr), .rdata(rf_rdata), .we(rf_we), .waddr(rf_waddr),
    .wdata(rf_wdata));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out();
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // expected effect of one instruction on accumulator, flags and file
  task predict(input abx_op_t op, input logic [7:0] kin, input logic [6:0] f,
    input logic [2:0] b, input logic d);
    logic [7:0] opnd, k, r;
    logic [8:0] s;
    logic [4:0] h;
    logic lit;
    opnd = (e_ioen && f == e_ioa) ? pin_level : e_mem[f];
    lit = (op == add_literal_op) || (op == and_literal_op);
    k = lit ? kin : opnd;
    s = {1'b0, e_acc} + {1'b0, k};
    h = {1'b0, e_acc[3:0]} + {1'b0, k[3:0]};
    r = (op == add_literal_op || op == add_register_op) ? s[7:0] : (e_acc & k);
    if (e_skip) begin
      e_skip = 1'b0;
    end else if (op <= and_literal_op) begin
      e_fl[2] = (r == 8'h00);
      if (op == add_literal_op || op == add_register_op) e_fl[1:0] = {h[4], s[8]};
      if (lit || !d) e_acc = r;
      else e_mem[f] = r;
    end else begin
      case (op)
        clear_bit_op: e_mem[f] = opnd & ~(8'h01 << b);
        set_bit_op: e_mem[f] = opnd | (8'h01 << b);
        skip_if_set_op: e_skip = opnd[b];
        skip_if_clear_op: e_skip = !opnd[b];
        clear_register_op: begin
          e_mem[f] = 8'h00;
          e_fl[2] = 1'b1;
        end
        default: ;
      endcase
    end
  endtask

  // offer one instruction and hold it until its slot takes it
  task issue(input abx_op_t op, input logic [7:0] k, input logic [6:0] f,
    input logic [2:0] b, input logic d);
    @(posedge aclk);
    predict(op, k, f, b, d);
    last_f = f;
    op_valid <= 1'b1;
    op_in <= {op, k, f, b, d};
    do @(posedge aclk); while (op_ready !== 1'b1);
  endtask

  // let the last instruction finish, then compare all results
  task finish();
    op_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(32'(acc_out), 32'(e_acc));
    chk(32'(flags_out), 32'(e_fl));
    chk(32'(rf.mem[last_f]), 32'(e_mem[last_f]));
  endtask

  task run_op(input abx_op_t op, input logic [7:0] k, input logic [6:0] f,
    input logic [2:0] b, input logic d);
    issue(op, k, f, b, d);
    finish();
  endtask

  // count skip request pulses seen at the far side
  always @(posedge aclk) begin
    if (skip_req === 1'b1) skips++;
  end

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog against a hung handshake
  initial begin
    #20000;
    fails++;
    close_out();
  end

  // main sequence
  initial begin
    {aresetn, op_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    op_in = '0;
    s_axi_wstrb = 4'hf;
    pin_level = 8'ha5;
    {fails, checks_done} = '0;
    {e_acc, e_fl, e_skip, e_ioen} = '0;
    e_ioa = 7'h06;
    for (int i = 0; i < 128; i++) begin
      rf.mem[i] = 8'(i * 37 + 3);
      e_mem[i] = 8'(i * 37 + 3);
    end
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped place, accumulator and status access
    axi_rd(`ABX_OFF_CTRL, 32'h0000_0601, `ABX_RESP_OKAY);
    axi_rd(`ABX_OFF_STAT, 32'h0000_0000, `ABX_RESP_OKAY);
    axi_wr(8'h0c, 32'h0000_00ff, `ABX_RESP_SLVERR);
    axi_rd(8'h0c, 32'h0000_0000, `ABX_RESP_SLVERR);
    axi_wr(`ABX_OFF_ACC, 32'h0000_003c, `ABX_RESP_OKAY);
    e_acc = 8'h3c;
    axi_wr(`ABX_OFF_STAT, 32'h0000_0005, `ABX_RESP_OKAY);
    e_fl = 3'b101;
    axi_rd(`ABX_OFF_STAT, 32'h0000_0005, `ABX_RESP_OKAY);
    $display("test registers done");
    // literal arithmetic across carry and zero boundaries
    run_op(add_literal_op, 8'hc4, 7'h00, 3'h0, 1'b0);
    run_op(add_literal_op, 8'hff, 7'h00, 3'h0, 1'b0);
    run_op(add_literal_op, 8'h01, 7'h00, 3'h0, 1'b0);
    run_op(add_literal_op, 8'h0f, 7'h00, 3'h0, 1'b0);
    run_op(and_literal_op, 8'hf0, 7'h00, 3'h0, 1'b0);
    $display("test literal done");
    // register operands with both destinations, top address included
    run_op(add_register_op, 8'h00, 7'h7f, 3'h0, 1'b0);
    run_op(add_register_op, 8'h00, 7'h7f, 3'h0, 1'b1);
    run_op(and_register_op, 8'h00, 7'h20, 3'h0, 1'b1);
    run_op(and_register_op, 8'h00, 7'h20, 3'h0, 1'b0);
    $display("test register done");
    // every bit index set and cleared
    for (int i = 0; i < 8; i++) begin
      run_op(set_bit_op, 8'h00, 7'h30, 3'(i), 1'b0);
      run_op(clear_bit_op, 8'h00, 7'h31, 3'(i), 1'b0);
    end
    $display("test bits done");
    // both skip tests, each taken once and not taken once, with an add right behind
    for (int i = 0; i < 4; i++) begin
      bi = {1'b0, i[0] ^ i[1], 1'b0};
      if (i < 2) issue(skip_if_set_op, 8'h00, 7'h40, bi, 1'b0);
      else issue(skip_if_clear_op, 8'h00, 7'h40, bi, 1'b0);
      issue(add_literal_op, 8'h11, 7'h00, 3'h0, 1'b0);
      finish();
    end
    chk(32'(skips), 32'h0000_0002);
    run_op(clear_register_op, 8'h00, 7'h50, 3'h0, 1'b0);
    $display("test skip and clear done");
    // port register read takes the pin levels
    axi_wr(`ABX_OFF_CTRL, 32'h0000_8601, `ABX_RESP_OKAY);
    e_ioen = 1'b1;
    run_op(add_register_op, 8'h00, 7'h06, 3'h0, 1'b0);
    run_op(set_bit_op, 8'h00, 7'h06, 3'h1, 1'b0);
    axi_rd(`ABX_OFF_ACC, 32'(e_acc), `ABX_RESP_OKAY);
    axi_rd(`ABX_OFF_STAT, 32'(e_fl), `ABX_RESP_OKAY);
    $display("test pins done");
    close_out();
  end
endmodule

`default_nettype wire
